// File: shared/dsc_decode_pkg.sv
// constants, field layouts and carrier types of the instruction decoder
// assumes one core clock where one enabled cycle is one instruction cycle
package dsc_decode_pkg;
  localparam int INSTR_W = 24;
  localparam int OPC_LSB = 16;
  // class nibble opcode[7:4]
  localparam logic [3:0] CLS_CTRL = 4'h0;
  localparam logic [3:0] CLS_CBRA = 4'h1;
  localparam logic [3:0] CLS_SKIP = 4'h2;
  localparam logic [3:0] CLS_REG = 4'h3;
  localparam logic [3:0] CLS_FILE = 4'h4;
  localparam logic [3:0] CLS_BIT = 4'h5;
  localparam logic [3:0] CLS_LIT5 = 4'h6;
  localparam logic [3:0] CLS_TEN_BIT_LITERAL = 4'h7;
  localparam logic [3:0] CLS_SIGNED_TEN_BIT_LITERAL = 4'h8;
  localparam logic [3:0] CLS_LIT16 = 4'h9;
  localparam logic [3:0] CLS_MAC = 4'hA;
  localparam logic [3:0] CLS_DSP = 4'hB;
  // control opcodes
  localparam logic [7:0] OP_NOP = 8'h00;
  localparam logic [7:0] OP_CALL_DW = 8'h02;
  localparam logic [7:0] OP_GOTO_DW = 8'h04;
  localparam logic [7:0] OP_BRANCH_ALWAYS = 8'h06;
  localparam logic [7:0] OP_BRANCH_COMPUTED = 8'h07;
  localparam logic [7:0] OP_CALL_IND = 8'h08;
  localparam logic [7:0] OP_GOTO_IND = 8'h09;
  localparam logic [7:0] OP_LOOP_DW = 8'h0A;
  localparam logic [7:0] OP_RETURN = 8'h0B;
  localparam logic [7:0] OP_RETURN_FROM_INTERRUPT = 8'h0C;
  localparam logic [7:0] OP_TABLE_READ = 8'h0D;
  localparam logic [7:0] OP_TABLE_WRITE = 8'h0E;
  // cycle counts
  localparam logic [1:0] CYC_ONE = 2'd1;
  localparam logic [1:0] CYC_TWO = 2'd2;
  localparam logic [1:0] CYC_THREE = 2'd3;
  // addressing modes
  localparam logic [2:0] AM_DIRECT = 3'd0;
  localparam logic [2:0] AM_INDIRECT = 3'd1;
  localparam logic [2:0] AM_POST_INC = 3'd2;
  localparam logic [2:0] AM_POST_DEC = 3'd3;
  localparam logic [2:0] AM_PRE_INC = 3'd4;
  localparam logic [2:0] AM_PRE_DEC = 3'd5;
  localparam logic [2:0] AM_REG_OFFSET = 3'd6;
  // operand sizes
  localparam logic [1:0] SZ_WORD = 2'd0;
  localparam logic [1:0] SZ_BYTE = 2'd1;
  localparam logic [1:0] SZ_DWORD = 2'd2;
  // write-back target codes
  localparam logic [1:0] WB_NONE = 2'd0;
  localparam logic [1:0] WB_DIRECT = 2'd1;
  localparam logic [1:0] WB_POST_INC2 = 2'd2;
  localparam logic [3:0] WB_REG = 4'd13;
  localparam logic [3:0] default_working_reg = 4'd0;
  localparam logic [9:0] BYTE_LIT_MAX = 10'h0FF;
  // flag bit positions
  localparam int FL_C = 0;
  localparam int FL_DC = 1;
  localparam int FL_N = 2;
  localparam int FL_OV = 3;
  localparam int FL_Z = 4;
  localparam int FL_OA = 5;
  localparam int FL_OB = 6;
  localparam int FL_SA = 7;
  localparam int FL_SB = 8;
  localparam int FL_W = 9;
  // bus map and reset values
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_FLAGS = 8'h04;
  localparam logic [7:0] ADDR_LAST = 8'h08;
  localparam logic [7:0] ADDR_INFO = 8'h0C;
  localparam logic CTRL_RST = 1'b1;

  typedef struct packed {
    logic [3:0] num;
    logic [2:0] mode;
  } reg_operand_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic [1:0] size;
    logic [3:0] base_reg_operand;
    reg_operand_t source_reg_operand;
    reg_operand_t dest_reg_operand;
    logic [12:0] file_addr;
    logic dest_is_file;
    logic [3:0] bit_index_field;
    logic bit_from_base;
    logic [15:0] literal;
    logic [22:0] program_address_literal;
    logic acc_sel;
    logic [2:0] mul_pair;
    logic [3:0] x_prefetch;
    logic [1:0] x_dest;
    logic [3:0] y_prefetch;
    logic [1:0] y_dest;
    logic [1:0] writeback_target;
    logic shift_by_lit;
    logic double_word;
    logic is_nop;
    logic illegal;
  } decoded_t;

  typedef struct packed {
    logic [FL_W-1:0] mask;
    logic [FL_W-1:0] value;
    logic z_sticky;
  } flag_upd_t;
endpackage

// File: logic/dsc_instruction_format_decode.sv
// instruction format decoder with issue sequencer, status flags and bus slave
// assumes fetch shows the following program word with every offered word
//
// Local design decisions: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module dsc_instruction_format_decode
  import dsc_decode_pkg::*;
#(
  parameter int WORD_W = INSTR_W
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // program memory side
  input wire logic instr_valid_in,
  input wire logic [WORD_W-1:0] instr_word_in,
  input wire logic [WORD_W-1:0] next_word_in,
  output logic fetch_ready_out,
  // execution side
  input wire logic cond_true_in,
  input wire flag_upd_t flag_upd_in,
  output decoded_t dec_out,
  output logic dec_valid_out,
  output logic nop_slot_out,
  output logic [1:0] cycles_out,
  output logic [1:0] words_used_out,
  output logic [1:0] skip_words_out,
  output logic [FL_W-1:0] flags_out,
  // register bus
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out
);
  if (WORD_W != INSTR_W) begin : g_chk
    $error("instruction width must be 24");
  end
  // package layout has to match the field slicing below
  if (OPC_LSB + 8 != INSTR_W) begin : g_chk_opc
    $error("opcode field must end at the top bit");
  end
  if (FL_W != 9) begin : g_chk_flags
    $error("flag word must be nine bits wide");
  end
  if (AM_REG_OFFSET == 3'd7) begin : g_chk_modes
    $error("mode code seven is kept for illegal modes");
  end

  typedef enum logic {SQ_ISSUE, SQ_STALL} seq_t;

  typedef struct packed {
    seq_t seq;
    logic [1:0] remain;
    logic fetch_ready;
    decoded_t dec;
    logic dec_valid;
    logic nop_slot;
    logic [1:0] cycles;
    logic [1:0] words_used;
    logic [1:0] skip_words;
    logic [FL_W-1:0] flags;
    logic ctrl_en;
    logic illegal_seen;
    logic [23:0] last_word;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    logic hreadyout;
  } state_t;

  state_t s_q, s_d;

  // three two-word opcodes only
  function automatic logic is_dw(input logic [7:0] op);
    return op == OP_CALL_DW || op == OP_GOTO_DW || op == OP_LOOP_DW;
  endfunction

  function automatic reg_operand_t wop(input logic [6:0] f, input logic allow_off);
    reg_operand_t r;
    r.num = f[3:0];
    r.mode = f[6:4];
    return r;
  endfunction

  function automatic logic bad_mode(input logic [2:0] m, input logic allow_off);
    return m == 3'd7 || (m == AM_REG_OFFSET && !allow_off);
  endfunction

  // class nibble, top half of the opcode
  function automatic logic [3:0] cls_of(input logic [7:0] op);
    return op[7:4];
  endfunction

  // control opcodes the issue logic knows; the rest run as no-op
  function automatic logic ctrl_known(input logic [7:0] op);
    unique case (op)
      OP_NOP, OP_CALL_DW, OP_GOTO_DW, OP_LOOP_DW, OP_BRANCH_ALWAYS, OP_BRANCH_COMPUTED: return 1'b1;
      OP_CALL_IND, OP_GOTO_IND, OP_RETURN, OP_RETURN_FROM_INTERRUPT: return 1'b1;
      OP_TABLE_READ, OP_TABLE_WRITE: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // write-back codes map onto register 13 direct or post-increment
  function automatic reg_operand_t wb_operand(input logic [1:0] code);
    reg_operand_t r;
    r.num = WB_REG;
    r.mode = code == WB_POST_INC2 ? AM_POST_INC : AM_DIRECT;
    return r;
  endfunction

  // fetch advance of a taken word; an illegal pair never claims its second word
  function automatic logic [1:0] words_of(input decoded_t d);
    return d.double_word ? 2'd2 : 2'd1;
  endfunction

  // words dropped behind a taken skip
  function automatic logic [1:0] skip_of(input decoded_t d, input logic cond, input logic nx_dw);
    logic [1:0] n;
    n = 2'd0;
    if (!d.illegal && cls_of(d.opcode) == CLS_SKIP && cond)
      n = nx_dw ? 2'd2 : 2'd1;
    return n;
  endfunction

  function automatic decoded_t decode(input logic [23:0] w, input logic [23:0] nx);
    decoded_t d;
    logic [7:0] op;
    d = '0;
    op = w[23:OPC_LSB];
    d.opcode = op;
    d.size = SZ_WORD;
    d.base_reg_operand = w[19:16];
    unique case (cls_of(op))
      CLS_CTRL: begin
        d.double_word = is_dw(op);
        d.program_address_literal = {nx[6:0], w[15:1], 1'b0};
        // second word must open with zero
        d.illegal = d.double_word && (w[0] || nx[23:16] != 8'h00);
        d.is_nop = op == OP_NOP;
        if (!ctrl_known(op)) d.illegal = 1'b1;
        d.source_reg_operand = wop(w[6:0], 1'b0);
      end
      CLS_CBRA, CLS_SKIP: begin
        d.literal = w[15:0];
        d.source_reg_operand = wop(w[6:0], 1'b0);
      end
      CLS_REG: begin
        d.size = w[15:14];
        d.source_reg_operand = wop(w[6:0], 1'b0);
        d.dest_reg_operand = wop(w[13:7], 1'b0);
        d.illegal = w[15:14] == 2'd3 || bad_mode(w[6:4], 1'b0) || bad_mode(w[13:11], 1'b0);
      end
      CLS_FILE: begin
        d.size = w[14] ? SZ_BYTE : SZ_WORD;
        d.dest_is_file = w[13];
        d.file_addr = w[12:0];
        d.dest_reg_operand.num = default_working_reg;
      end
      CLS_BIT: begin
        d.dest_is_file = w[15];
        d.bit_from_base = w[14];
        d.bit_index_field = w[19:16];
        d.file_addr = w[12:0];
        d.source_reg_operand = wop(w[6:0], 1'b0);
        d.illegal = !w[15] && bad_mode(w[6:4], 1'b0);
      end
      CLS_LIT5: begin
        d.size = w[15] ? SZ_BYTE : SZ_WORD;
        d.literal = {11'h000, w[11:7]};
        d.dest_reg_operand = w[14] ? wop(w[6:0], 1'b0) : reg_operand_t'{num: w[19:16], mode: AM_DIRECT};
        d.illegal = w[14] && bad_mode(w[6:4], 1'b0);
      end
      CLS_TEN_BIT_LITERAL: begin
        d.size = w[15] ? SZ_BYTE : SZ_WORD;
        d.literal = {6'h00, w[14:5]};
        d.dest_reg_operand.num = w[3:0];
        d.illegal = w[15] && w[14:5] > BYTE_LIT_MAX;
      end
      CLS_SIGNED_TEN_BIT_LITERAL: begin
        d.literal = {{6{w[15]}}, w[15:6]};
        d.dest_reg_operand.num = w[3:0];
      end
      CLS_LIT16: begin
        d.literal = w[19:4];
        d.dest_reg_operand.num = w[3:0];
      end
      CLS_MAC: begin
        d.acc_sel = w[19];
        d.mul_pair = w[18:16];
        d.x_prefetch = w[15:12];
        d.x_dest = w[11:10];
        d.y_prefetch = w[9:6];
        d.y_dest = w[5:4];
        d.writeback_target = w[3:2];
        d.dest_reg_operand = wb_operand(w[3:2]);
        d.illegal = w[3:2] == 2'd3 || w[18:16] > 3'd5;
      end
      CLS_DSP: begin
        d.acc_sel = w[19];
        d.shift_by_lit = w[18];
        d.literal = {{10{w[17]}}, w[17:12]};
        d.base_reg_operand = w[11:8];
        d.dest_reg_operand = wop(w[6:0], 1'b1);
        d.illegal = bad_mode(w[6:4], 1'b1) || (w[6:4] == AM_REG_OFFSET && !w[18]);
      end
      default: d.illegal = 1'b1;
    endcase
    // an illegal word runs as a lone no-op and hands its second word back to fetch
    if (d.illegal) begin
      d.is_nop = 1'b1;
      d.double_word = 1'b0;
    end
    return d;
  endfunction

  function automatic logic [1:0] cyc_of(input decoded_t d, input logic cond, input logic nx_dw);
    logic [1:0] c;
    c = CYC_ONE;
    if (!d.illegal) begin
      unique case (cls_of(d.opcode))
        CLS_CTRL: begin
          unique case (d.opcode)
            OP_CALL_DW, OP_GOTO_DW, OP_LOOP_DW: c = CYC_TWO;
            OP_RETURN, OP_RETURN_FROM_INTERRUPT: c = CYC_THREE;
            OP_BRANCH_ALWAYS, OP_BRANCH_COMPUTED, OP_CALL_IND, OP_GOTO_IND,
            OP_TABLE_READ, OP_TABLE_WRITE: c = CYC_TWO;
            default: c = CYC_ONE;
          endcase
        end
        CLS_CBRA: c = cond ? CYC_TWO : CYC_ONE;
        CLS_SKIP: c = !cond ? CYC_ONE : (nx_dw ? CYC_THREE : CYC_TWO);
        CLS_REG: c = d.size == SZ_DWORD ? CYC_TWO : CYC_ONE;
        default: c = CYC_ONE;
      endcase
    end
    return c;
  endfunction

  function automatic logic [31:0] rd(input logic [7:0] a, input state_t s);
    unique case (a)
      ADDR_CTRL: return {31'h0, s.ctrl_en};
      ADDR_FLAGS: return {23'h0, s.flags};
      ADDR_LAST: return {8'h00, s.last_word};
      ADDR_INFO: return {29'h0, s.seq == SQ_STALL, s.fetch_ready, s.illegal_seen};
      default: return 32'h0000_0000;
    endcase
  endfunction

  always_comb begin
    decoded_t nd;
    logic [1:0] nc;
    logic take;
    logic nx_dw;
    logic bus_take;
    nx_dw = is_dw(next_word_in[23:OPC_LSB]);
    nd = decode(instr_word_in, next_word_in);
    nc = cyc_of(nd, cond_true_in, nx_dw);
    take = instr_valid_in && s_q.fetch_ready;
    bus_take = hsel_in && htrans_in[1] && hready_in;
    s_d = s_q;
    s_d.dec_valid = 1'b0;
    s_d.nop_slot = 1'b0;
    unique case (s_q.seq)
      SQ_ISSUE: begin
        s_d.fetch_ready = s_q.ctrl_en;
        if (take) begin
          s_d.dec = nd;
          s_d.dec_valid = 1'b1;
          s_d.cycles = nc;
          s_d.words_used = words_of(nd);
          s_d.skip_words = skip_of(nd, cond_true_in, nx_dw);
          s_d.last_word = instr_word_in;
          if (nd.illegal) s_d.illegal_seen = 1'b1;
          if (nc != CYC_ONE) begin
            s_d.seq = SQ_STALL;
            s_d.remain = nc - 2'd1;
            s_d.fetch_ready = 1'b0;
          end
        end
      end
      SQ_STALL: begin
        s_d.nop_slot = 1'b1;
        s_d.remain = s_q.remain - 2'd1;
        if (s_q.remain == 2'd1) begin
          s_d.seq = SQ_ISSUE;
          s_d.fetch_ready = s_q.ctrl_en;
        end
      end
    endcase
    // bus data phase write; hardware updates below win
    if (s_q.wr_pend) begin
      unique case (s_q.wr_addr)
        ADDR_CTRL: s_d.ctrl_en = hwdata_in[0];
        ADDR_FLAGS: s_d.flags = hwdata_in[FL_W-1:0];
        ADDR_INFO: if (hwdata_in[0]) s_d.illegal_seen = take && nd.illegal;
        default: ;
      endcase
      if (s_q.wr_addr == ADDR_CTRL && !hwdata_in[0]) s_d.fetch_ready = 1'b0;
    end
    for (int i = 0; i < FL_W; i++) begin
      if (flag_upd_in.mask[i]) begin
        if (i == FL_Z && flag_upd_in.z_sticky)
          s_d.flags[i] = s_q.flags[i] & flag_upd_in.value[i];
        else
          s_d.flags[i] = flag_upd_in.value[i];
      end
    end
    // bus address phase, zero wait
    s_d.hreadyout = 1'b1;
    s_d.wr_pend = 1'b0;
    if (bus_take) begin
      s_d.wr_pend = hwrite_in;
      s_d.wr_addr = haddr_in[7:0];
      if (!hwrite_in) s_d.rdata = rd(haddr_in[7:0], s_q);
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_q <= '0;
      s_q.seq <= SQ_ISSUE;
      s_q.ctrl_en <= CTRL_RST;
      s_q.hreadyout <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign fetch_ready_out = s_q.fetch_ready;
  assign dec_out = s_q.dec;
  assign dec_valid_out = s_q.dec_valid;
  assign nop_slot_out = s_q.nop_slot;
  assign cycles_out = s_q.cycles;
  assign words_used_out = s_q.words_used;
  assign skip_words_out = s_q.skip_words;
  assign flags_out = s_q.flags;
  assign hrdata_out = s_q.rdata;
  assign hreadyout_out = s_q.hreadyout;
  assign hresp_out = 1'b0;
endmodule // dsc_instruction_format_decode
`default_nettype wire

// File: bench/prog_mem_model.sv
// program memory model feeding instruction words and their successors
// assumes the bench loads the image and raises go_in after reset
`timescale 1ns/1ns
`default_nettype none
module prog_mem_model (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // image from the bench
  input wire logic go_in,
  input wire logic [5:0] len_in,
  input wire logic [24:0] prog_in [0:31],
  // decoder side
  input wire logic ready_in,
  input wire logic dec_valid_in,
  input wire logic [1:0] words_in,
  input wire logic [1:0] skip_in,
  output logic valid_out,
  output logic cond_out,
  output logic [23:0] word_out,
  output logic [23:0] next_out
);
  logic [5:0] pc_q;
  logic [23:0] last_q;
  logic [5:0] step;
  assign valid_out = go_in && (pc_q < len_in);
  // idle word line shows the inverted last word; the next line shows the last word itself
  assign word_out = valid_out ? prog_in[pc_q[4:0]][23:0] : ~last_q;
  assign next_out = valid_out ? prog_in[pc_q[4:0] + 5'h1][23:0] : last_q;
  assign cond_out = valid_out && prog_in[pc_q[4:0]][24];
  // one word per take; size and skip are known only a cycle later
  assign step = dec_valid_in ? 6'(words_in) + 6'(skip_in) - 6'h1 : 6'h0;
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pc_q <= 6'h0;
      last_q <= 24'h00_0000;
    end else if (!go_in) begin
      pc_q <= 6'h0;
    end else begin
      pc_q <= pc_q + 6'(valid_out && ready_in) + step;
      if (valid_out)
        last_q <= word_out;
    end
  end
endmodule // prog_mem_model
`default_nettype wire

// File: bench/dsc_decode_monitor.sv
// port checker for the instruction format decoder
// assumes one core clock and the decoder's own reset
`timescale 1ns/1ns
`default_nettype none
module dsc_decode_monitor
  import dsc_decode_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // decoder ports
  input wire logic instr_valid_in,
  input wire logic fetch_ready_out,
  input wire flag_upd_t flag_upd_in,
  input wire decoded_t dec_out,
  input wire logic dec_valid_out,
  input wire logic nop_slot_out,
  input wire logic [1:0] cycles_out,
  input wire logic [1:0] words_used_out,
  input wire logic [1:0] skip_words_out,
  input wire logic [FL_W-1:0] flags_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);
  wire logic dv = dec_valid_out;
  a_take_answered: assert property (
    instr_valid_in && fetch_ready_out |=> dv) else $error("taken word got no decode");
  a_decode_cause: assert property (
    dv |-> $past(instr_valid_in && fetch_ready_out)) else $error("decode without a take");
  a_two_cyc_slot: assert property (
    dv && cycles_out == CYC_TWO |-> !fetch_ready_out ##1 nop_slot_out) else $error("missing no-op slot");
  a_three_cyc_slots: assert property (
    dv && cycles_out == CYC_THREE |-> !fetch_ready_out ##1 (nop_slot_out && !fetch_ready_out) ##1 nop_slot_out)
    else $error("missing no-op slots");
  a_dword_two_cyc: assert property (
    dv && words_used_out == 2'h2 |-> cycles_out == CYC_TWO) else $error("two-word cycle count");
  a_skip_cost: assert property (
    dv && skip_words_out != 2'h0 |-> cycles_out == skip_words_out + 2'h1) else $error("skip cycle count");
  a_addr_lsb_zero: assert property (
    dv && words_used_out == 2'h2 |-> !dec_out.program_address_literal[0]) else $error("odd program address");
  a_lone_word_nop: assert property (
    dv && dec_out.opcode == OP_NOP |-> cycles_out == CYC_ONE && words_used_out == 2'h1)
    else $error("no-op word not single cycle");
  a_carry_update: assert property (
    flag_upd_in.mask[FL_C] |=> flags_out[FL_C] == $past(flag_upd_in.value[FL_C])) else $error("carry update");
  a_acc_clamp_update: assert property (
    flag_upd_in.mask[FL_SA] |=> flags_out[FL_SA] == $past(flag_upd_in.value[FL_SA])) else $error("clamp update");
  a_zero_sticky: assert property (
    flag_upd_in.mask[FL_Z] && flag_upd_in.z_sticky
    |=> flags_out[FL_Z] == ($past(flags_out[FL_Z]) && $past(flag_upd_in.value[FL_Z])))
    else $error("sticky zero update");
  c_three_cyc: cover property (dv && cycles_out == CYC_THREE);
  c_skip_two: cover property (dv && skip_words_out == 2'h2);
  c_two_words: cover property (dv && words_used_out == 2'h2);
endmodule // dsc_decode_monitor
bind dsc_instruction_format_decode dsc_decode_monitor u_mon (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
  .instr_valid_in(instr_valid_in), .fetch_ready_out(fetch_ready_out), .flag_upd_in(flag_upd_in),
  .dec_out(dec_out), .dec_valid_out(dec_valid_out), .nop_slot_out(nop_slot_out), .cycles_out(cycles_out),
  .words_used_out(words_used_out), .skip_words_out(skip_words_out), .flags_out(flags_out));
`default_nettype wire

// File: bench/tb.sv
// self-checking bench for the instruction format decoder
// assumes the program memory model and the bound port checker
`timescale 1ns/1ns
`default_nettype none
module tb;
  import dsc_decode_pkg::*;
  localparam int NR = 32;
  // cond, word, expected cycles/words/skip in 2-bit groups; 0 = not decoded
  localparam logic [30:0] ROWS [NR] = '{
    {1'h0,24'h00_0000,6'h14}, {1'h0,24'h02_1234,6'h28}, {1'h0,24'h00_0005,6'h00},
    {1'h0,24'h04_0010,6'h28}, {1'h0,24'h00_0001,6'h00}, {1'h0,24'h0A_0000,6'h28},
    {1'h0,24'h00_0000,6'h00}, {1'h0,24'h06_0000,6'h24}, {1'h0,24'h07_0000,6'h24},
    {1'h0,24'h08_0000,6'h24}, {1'h0,24'h09_0000,6'h24}, {1'h0,24'h0D_0000,6'h24},
    {1'h0,24'h0E_0000,6'h24}, {1'h0,24'h0B_0000,6'h34}, {1'h0,24'h0C_0000,6'h34},
    {1'h1,24'h10_0000,6'h24}, {1'h0,24'h10_0000,6'h14}, {1'h0,24'h20_0000,6'h14},
    {1'h1,24'h20_0000,6'h25}, {1'h0,24'h30_0000,6'h00}, {1'h1,24'h20_0000,6'h36},
    {1'h0,24'h02_0000,6'h00}, {1'h0,24'h00_0000,6'h00}, {1'h0,24'h00_1234,6'h14},
    {1'h0,24'h02_0000,6'h14}, {1'h0,24'h01_0000,6'h14}, {1'h0,24'h04_0001,6'h14},
    {1'h0,24'h00_00A5,6'h14}, {1'h0,24'h30_8000,6'h24}, {1'h0,24'h70_FFE0,6'h14},
    {1'h0,24'hA0_0008,6'h14}, {1'h0,24'h80_8000,6'h14}};
  logic sys_clk_in, resetn_in, go, instr_valid_in, fetch_ready_out, cond_true_in;
  logic dec_valid_out, nop_slot_out, hsel_in, hwrite_in, hready_in, hreadyout_out, hresp_out;
  logic [23:0] instr_word_in, next_word_in;
  logic [1:0] cycles_out, words_used_out, skip_words_out, htrans_in;
  logic [FL_W-1:0] flags_out;
  logic [31:0] haddr_in, hwdata_in, hrdata_out, rd;
  logic [2:0] hsize_in;
  logic [24:0] prog [0:31];
  flag_upd_t flag_upd_in;
  decoded_t dec_out;
  int num_errors, comparisons;
  assign hready_in = hreadyout_out;
  dsc_instruction_format_decode dut (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
    .instr_valid_in(instr_valid_in), .instr_word_in(instr_word_in), .next_word_in(next_word_in),
    .fetch_ready_out(fetch_ready_out), .cond_true_in(cond_true_in), .flag_upd_in(flag_upd_in),
    .dec_out(dec_out), .dec_valid_out(dec_valid_out), .nop_slot_out(nop_slot_out), .cycles_out(cycles_out),
    .words_used_out(words_used_out), .skip_words_out(skip_words_out), .flags_out(flags_out),
    .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in),
    .hwdata_in(hwdata_in), .hready_in(hready_in), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out));
  prog_mem_model u_mem (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .go_in(go), .len_in(6'(NR)),
    .prog_in(prog), .ready_in(fetch_ready_out), .dec_valid_in(dec_valid_out), .words_in(words_used_out),
    .skip_in(skip_words_out), .valid_out(instr_valid_in), .cond_out(cond_true_in),
    .word_out(instr_word_in), .next_out(next_word_in));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // single word transfer; the master holds each phase until hready is seen
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel_in <= 1'h1;
    htrans_in <= 2'h2;
    haddr_in <= {24'h00_0000, a};
    hwrite_in <= w;
    @(posedge sys_clk_in);
    while (hreadyout_out !== 1'h1) @(posedge sys_clk_in);
    hsel_in <= 1'h0;
    htrans_in <= 2'h0;
    hwdata_in <= d;
    @(posedge sys_clk_in);
    while (hreadyout_out !== 1'h1) @(posedge sys_clk_in);
    r = hrdata_out;
    chk(32'(hresp_out), 32'h0000_0000);
  endtask
  task automatic fl(input logic [8:0] m, input logic [8:0] v, input logic z, input logic [31:0] exp);
    flag_upd_in <= {m, v, z};
    @(posedge sys_clk_in);
    flag_upd_in <= '0;
    @(posedge sys_clk_in);
    #1;
    chk(32'(flags_out), exp);
  endtask
  task automatic wait_dec;
    int n;
    n = 0;
    do begin
      @(posedge sys_clk_in);
      #1;
      n++;
    end while (dec_valid_out !== 1'h1 && n < 40);
    chk(32'(dec_valid_out), 32'h0000_0001);
  endtask
  initial begin
    sys_clk_in = 1'h0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  // the whole run needs well under two thousand cycles
  initial begin
    #20000;
    num_errors++;
    end_sim();
  end
  initial begin
    resetn_in = 1'h0;
    go = 1'h0;
    hsel_in = 1'h0;
    hwrite_in = 1'h0;
    htrans_in = 2'h0;
    hsize_in = 3'h2;
    haddr_in = 32'h0000_0000;
    hwdata_in = 32'h0000_0000;
    flag_upd_in = '0;
    num_errors = 0;
    comparisons = 0;
    for (int i = 0; i < 32; i++)
      prog[i] = (i < NR) ? ROWS[i][30:6] : 25'h000_0000;
    repeat (6) @(posedge sys_clk_in);
    resetn_in <= 1'h1;
    @(posedge sys_clk_in);
    bus(1'h0, ADDR_CTRL, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0001);
    bus(1'h0, ADDR_FLAGS, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0000);
    go <= 1'h1;
    for (int i = 0; i < NR; i++) begin
      if (ROWS[i][5:4] != 2'h0) begin
        wait_dec();
        chk(32'({cycles_out, words_used_out, skip_words_out}), 32'(ROWS[i][5:0]));
        if (i == 1)
          chk(32'(dec_out.program_address_literal), 32'({7'h05, 15'h091A, 1'h0}));
        if (i == 28)
          chk(32'(dec_out.size), 32'(SZ_DWORD));
        if (i == 29)
          chk(32'(dec_out.illegal), 32'h0000_0001);
        if (i == 30)
          chk(32'(dec_out.dest_reg_operand), 32'({WB_REG, AM_POST_INC}));
        if (i == 31)
          chk(32'(dec_out.literal), 32'h0000_FE00);
      end
    end
    go <= 1'h0;
    bus(1'h0, ADDR_LAST, 32'h0000_0000, rd);
    chk(rd, {8'h00, ROWS[NR-1][29:6]});
    bus(1'h0, ADDR_INFO, 32'h0000_0000, rd);
    chk(32'(rd[2:0]), 32'h0000_0003);
    bus(1'h1, ADDR_INFO, 32'h0000_0001, rd);
    bus(1'h0, ADDR_INFO, 32'h0000_0000, rd);
    chk(32'(rd[2:0]), 32'h0000_0002);
    bus(1'h0, 8'h10, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0000);
    bus(1'h1, ADDR_FLAGS, 32'hFFFF_FFFF, rd);
    bus(1'h0, ADDR_FLAGS, 32'h0000_0000, rd);
    chk(rd, 32'h0000_01FF);
    fl(9'h0A1, 9'h000, 1'h0, 32'h0000_015E);
    fl(9'h010, 9'h010, 1'h1, 32'h0000_015E);
    fl(9'h010, 9'h000, 1'h1, 32'h0000_014E);
    fl(9'h010, 9'h010, 1'h1, 32'h0000_014E);
    fl(9'h010, 9'h010, 1'h0, 32'h0000_015E);
    // fetch refused while decode is switched off, resumes after
    bus(1'h1, ADDR_CTRL, 32'h0000_0000, rd);
    repeat (2) @(posedge sys_clk_in);
    go <= 1'h1;
    repeat (3) @(posedge sys_clk_in);
    #1;
    chk(32'(fetch_ready_out), 32'h0000_0000);
    bus(1'h1, ADDR_CTRL, 32'h0000_0001, rd);
    wait_dec();
    chk(32'({cycles_out, words_used_out, skip_words_out}), 32'h0000_0014);
    repeat (3) @(posedge sys_clk_in);
    resetn_in <= 1'h0;
    @(posedge sys_clk_in);
    #1;
    chk(32'(flags_out), 32'h0000_0000);
    chk(32'(fetch_ready_out), 32'h0000_0000);
    resetn_in <= 1'h1;
    @(posedge sys_clk_in);
    bus(1'h0, ADDR_CTRL, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0001);
    end_sim();
  end
endmodule // tb
`default_nettype wire
